// ===== include/phy_regs_pkg.sv
// Function
// - count invalid 100 Mb/s symbols, idle too
// - at most one count per packet
// - counter wraps to zero past maximum
// - reset clears counter; reads leave it alone
// - counter holds in 10 Mb/s mode
// - bit 15 picks straps or register bits
// - enable/state bits select crossover mode
// - straps: auto strap wins, else manual
// - bit 11 disables heartbeat test
// - bit 5 enables far-end fault
// - far-end fault resets to fiber mode
// - bit 4 shows 10 Mb/s polarity
// - phy soft reset clears bits 14,13,11
// - reserved bits are read-only
`default_nettype none
package phy_regs_pkg;
  localparam int unsigned DATA_W        = 32;     // apb data width
  localparam int unsigned ADDR_W        = 8;      // apb byte address width
  localparam int unsigned REG_W         = 16;     // management register width
  localparam logic [5:0]  SYMERR_IDX    = 6'h1a;  // counter register index
  localparam logic [5:0]  SPECIAL_IDX   = 6'h1b;  // special control index
  localparam logic [7:0]  SYMERR_ADDR   = {SYMERR_IDX, 2'b00};
  localparam logic [7:0]  SPECIAL_ADDR  = {SPECIAL_IDX, 2'b00};
  // field positions in the special control register
  localparam int unsigned SRC_SEL_BIT   = 15;
  localparam int unsigned AUTO_EN_BIT   = 14;
  localparam int unsigned STATE_BIT     = 13;
  localparam int unsigned HB_DIS_BIT    = 11;
  localparam int unsigned FEF_EN_BIT    = 5;
  localparam int unsigned POL_BIT       = 4;
  // reset values
  localparam logic [15:0] SYMERR_RST    = 16'h0000;
  localparam logic        SRC_SEL_RST   = 1'b0;
  localparam logic        AUTO_EN_RST   = 1'b0;
  localparam logic        STATE_RST     = 1'b0;
  localparam logic        HB_DIS_RST    = 1'b0;
  localparam logic        FEF_FIBER_RST = 1'b1;
  localparam logic        FEF_OTHER_RST = 1'b0;
  localparam logic        POL_RST       = 1'b0;

  // resulting crossover behaviour of the port
  typedef enum logic [1:0] {
    XOVER_STRAIGHT = 2'h0,
    XOVER_CROSS    = 2'h1,
    XOVER_AUTO     = 2'h2
  } xover_mode_e;

  // per-packet counting state, one-hot
  typedef enum logic [1:0] {
    PKT_OPEN    = 2'h1,
    PKT_COUNTED = 2'h2
  } pkt_state_e;
endpackage
`default_nettype wire

// ===== include/xover_if.sv
`timescale 1ns/10ps
`default_nettype none
// crossover configuration handed from the register bank to the decoder
interface xover_if;
  import phy_regs_pkg::*;
  logic        src_sel;       // 1: register bits govern
  logic        auto_en;       // register auto enable
  logic        state;         // register crossover state
  logic        auto_strap;    // auto crossover strap
  logic        manual_strap;  // manual crossover strap
  xover_mode_e mode;          // decoded mode
  modport ctrl (output src_sel, auto_en, state, auto_strap, manual_strap, input mode);
  modport sel  (input src_sel, auto_en, state, auto_strap, manual_strap, output mode);
endinterface
`default_nettype wire

// ===== rtl/xover_select.sv
`timescale 1ns/10ps
`default_nettype none
// pure decode of the crossover source and mode
module xover_select (
  xover_if.sel xo
);
  import phy_regs_pkg::*;

  // straps or register bits, auto request dominates in both
  always_comb begin
    if (xo.src_sel) begin
      if (xo.auto_en) begin
        xo.mode = XOVER_AUTO;
      end else if (xo.state) begin
        xo.mode = XOVER_CROSS;
      end else begin
        xo.mode = XOVER_STRAIGHT;
      end
    end else begin
      if (xo.auto_strap) begin
        xo.mode = XOVER_AUTO;
      end else if (xo.manual_strap) begin
        xo.mode = XOVER_CROSS;
      end else begin
        xo.mode = XOVER_STRAIGHT;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/symerr_counter.sv
`timescale 1ns/10ps
`default_nettype none
// receive symbol error counter, one step per packet at most
module symerr_counter #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  input  wire logic             sym_err_in,     // invalid symbol seen, one cycle
  input  wire logic             pkt_active_in,  // packet being received
  input  wire logic             mode_10bt_in,   // port runs 10 Mb/s twisted pair
  output logic [CNT_W-1:0]      count_out
);
  import phy_regs_pkg::*;

  pkt_state_e pkt_state;  // has this packet already counted
  logic       bump;       // count this cycle

  // idle errors always count outside 10 Mb/s mode; in a packet only the first does
  assign bump = ce_in && sym_err_in && !mode_10bt_in &&
                (!pkt_active_in || pkt_state == PKT_OPEN);

  // packet state tracking
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pkt_state <= PKT_OPEN;
    end else if (ce_in) begin
      case (pkt_state)
        PKT_OPEN: begin
          if (pkt_active_in && bump) begin
            pkt_state <= PKT_COUNTED;
          end
        end
        PKT_COUNTED: begin
          if (!pkt_active_in) begin
            pkt_state <= PKT_OPEN;
          end
        end
        default: begin
          pkt_state <= PKT_OPEN;
        end
      endcase
    end
  end

  // counter rolls over naturally at full width
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_out <= CNT_W'(SYMERR_RST);
    end else if (bump) begin
      count_out <= count_out + 1'b1;
    end
  end

  once_per_pkt_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (pkt_state == PKT_COUNTED && pkt_active_in) |=> $stable(count_out))
    else $error("counter advanced twice in one packet");
  hold_10bt_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    mode_10bt_in |=> $stable(count_out))
    else $error("counter moved in 10 Mb/s mode");
  wrap_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (bump && &count_out) |=> (count_out == '0))
    else $error("counter failed to wrap");
  count_err_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && sym_err_in && !mode_10bt_in && !pkt_active_in) |=>
      (count_out == $past(count_out) + 1'b1))
    else $error("idle symbol error not counted");
  wrap_c: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    bump && &count_out);
endmodule
`default_nettype wire

// ===== rtl/phy_symerr_crossover_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// symbol error counter and special control/status registers over apb
module phy_symerr_crossover_ctrl #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                              clk_in,
  input  wire logic                              arst_n_in,
  input  wire logic                              ce_in,
  // apb slave
  input  wire logic                              psel_in,
  input  wire logic                              penable_in,
  input  wire logic                              pwrite_in,
  input  wire logic [phy_regs_pkg::ADDR_W-1:0]   paddr_in,
  input  wire logic [phy_regs_pkg::DATA_W-1:0]   pwdata_in,
  output logic      [phy_regs_pkg::DATA_W-1:0]   prdata_out,
  output logic                                   pready_out,
  output logic                                   pslverr_out,
  // phy receive side
  input  wire logic                              sym_err_in,
  input  wire logic                              pkt_active_in,
  input  wire logic                              mode_10bt_in,
  input  wire logic                              fiber_mode_in,
  input  wire logic                              polarity_reversed_in,
  // phy reset through the reset control register
  input  wire logic                              phy_reset_req_in,
  input  wire logic                              phy_soft_reset_bit_in,
  // straps
  input  wire logic                              auto_strap_in,
  input  wire logic                              manual_strap_in,
  // control outputs to the phy
  output phy_regs_pkg::xover_mode_e              crossover_mode_out,
  output logic                                   heartbeat_test_disable_out,
  output logic                                   far_end_fault_enable_out
);
  import phy_regs_pkg::*;

  xover_if xo ();  // link to the crossover decoder

  logic               crossover_source_select;  // 0 straps, 1 register
  logic               crossover_auto_enable;    // register auto request
  logic               crossover_state;          // register manual state
  logic               heartbeat_test_disable;   // 1 disables heartbeat
  logic               far_end_fault_enable;     // far-end fault gen/detect
  logic               fef_loaded;               // mode-dependent default taken
  logic               twisted_pair_polarity_reversed;  // captured status
  logic [CNT_W-1:0]   symbol_error_count;       // live counter value
  logic               phy_reset_only_field;     // soft phy reset strobe
  logic               setup_phase;              // apb setup cycle
  logic               access_phase;             // apb access cycle
  logic               hit_symerr;               // address decodes counter
  logic               hit_special;              // address decodes control
  logic               wr_special;               // write lands this edge
  logic [REG_W-1:0]   special_view;             // readback image
  logic [DATA_W-1:0]  next_prdata;              // read mux result

  // the soft-reset designation only bites with the soft reset bit set
  assign phy_reset_only_field = phy_reset_req_in && phy_soft_reset_bit_in;

  // apb phase and decode
  assign setup_phase  = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign hit_symerr   = (paddr_in == SYMERR_ADDR);
  assign hit_special  = (paddr_in == SPECIAL_ADDR);

  // zero wait states; a frozen clock enable stretches the access phase
  assign pready_out  = access_phase && ce_in;
  // unmapped addresses answer with an error and change nothing
  assign pslverr_out = pready_out && !(hit_symerr || hit_special);
  // counter writes fall through here untouched
  assign wr_special  = pready_out && pwrite_in && hit_special;

  // readback image, reserved positions tied low
  always_comb begin
    special_view              = '0;
    special_view[SRC_SEL_BIT] = crossover_source_select;
    special_view[AUTO_EN_BIT] = crossover_auto_enable;
    special_view[STATE_BIT]   = crossover_state;
    special_view[HB_DIS_BIT]  = heartbeat_test_disable;
    special_view[FEF_EN_BIT]  = far_end_fault_enable;
    special_view[POL_BIT]     = twisted_pair_polarity_reversed;
  end

  // read mux, upper half of the word reads zero
  always_comb begin
    next_prdata = '0;
    if (hit_symerr) begin
      next_prdata[REG_W-1:0] = REG_W'(symbol_error_count);
    end else if (hit_special) begin
      next_prdata[REG_W-1:0] = special_view;
    end
  end

  // read data registered in setup so it is steady through access
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= '0;
    end else if (ce_in && setup_phase) begin
      prdata_out <= next_prdata;
    end
  end

  // source select survives a soft phy reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crossover_source_select <= SRC_SEL_RST;
    end else if (wr_special) begin
      crossover_source_select <= pwdata_in[SRC_SEL_BIT];
    end
  end

  // crossover bits; soft phy reset beats a simultaneous write
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crossover_auto_enable <= AUTO_EN_RST;
      crossover_state       <= STATE_RST;
    end else if (ce_in && phy_reset_only_field) begin
      crossover_auto_enable <= AUTO_EN_RST;
      crossover_state       <= STATE_RST;
    end else if (wr_special) begin
      // the both-set combination is stored as written, no guard
      crossover_auto_enable <= pwdata_in[AUTO_EN_BIT];
      crossover_state       <= pwdata_in[STATE_BIT];
    end
  end

  // heartbeat test disable, also cleared by soft phy reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      heartbeat_test_disable <= HB_DIS_RST;
    end else if (ce_in && phy_reset_only_field) begin
      heartbeat_test_disable <= HB_DIS_RST;
    end else if (wr_special) begin
      heartbeat_test_disable <= pwdata_in[HB_DIS_BIT];
    end
  end

  // far-end fault: async reset gives a constant, the fiber-dependent
  // default is caught on the first enabled edge after release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      far_end_fault_enable <= FEF_OTHER_RST;
      fef_loaded           <= 1'b0;
    end else if (ce_in && !fef_loaded) begin
      far_end_fault_enable <= fiber_mode_in ? FEF_FIBER_RST : FEF_OTHER_RST;
      fef_loaded           <= 1'b1;
    end else if (wr_special) begin
      far_end_fault_enable <= pwdata_in[FEF_EN_BIT];
    end
  end

  // polarity status follows the receiver, writes cannot reach it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      twisted_pair_polarity_reversed <= POL_RST;
    end else if (ce_in) begin
      twisted_pair_polarity_reversed <= polarity_reversed_in;
    end
  end

  // crossover decode inputs
  assign xo.src_sel      = crossover_source_select;
  assign xo.auto_en      = crossover_auto_enable;
  assign xo.state        = crossover_state;
  assign xo.auto_strap   = auto_strap_in;
  assign xo.manual_strap = manual_strap_in;

  xover_select u_xover (
    .xo (xo.sel)
  );

  // registered crossover mode output, one cycle behind the fields
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crossover_mode_out <= XOVER_STRAIGHT;
    end else if (ce_in) begin
      crossover_mode_out <= xo.mode;
    end
  end

  // plain field mirrors; the fields are flops already
  assign heartbeat_test_disable_out = heartbeat_test_disable;
  assign far_end_fault_enable_out   = far_end_fault_enable;

  symerr_counter #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .ce_in         (ce_in),
    .sym_err_in    (sym_err_in),
    .pkt_active_in (pkt_active_in),
    .mode_10bt_in  (mode_10bt_in),
    .count_out     (symbol_error_count)
  );

  // checks, all in the single clock domain
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // the release edge still shows reset outputs, so it never starts a check
  xover_strap_a: assert property (
    (arst_n_in && ce_in && !crossover_source_select) ##1 ce_in |->
      crossover_mode_out == ($past(auto_strap_in) ? XOVER_AUTO :
        ($past(manual_strap_in) ? XOVER_CROSS : XOVER_STRAIGHT)))
    else $error("strap crossover mode wrong");
  xover_reg_a: assert property (
    (ce_in && crossover_source_select && !crossover_auto_enable) |=>
      crossover_mode_out == ($past(crossover_state) ? XOVER_CROSS : XOVER_STRAIGHT))
    else $error("register crossover mode wrong");
  src_sel_write_a: assert property (
    wr_special |=> crossover_source_select == $past(pwdata_in[SRC_SEL_BIT]))
    else $error("source select not written");
  hb_write_a: assert property (
    (wr_special && !phy_reset_only_field) |=>
      heartbeat_test_disable_out == $past(pwdata_in[HB_DIS_BIT]))
    else $error("heartbeat disable not written");
  soft_reset_a: assert property (
    (ce_in && phy_reset_only_field) |=>
      !crossover_auto_enable && !crossover_state && !heartbeat_test_disable)
    else $error("soft phy reset left fields set");
  fef_default_a: assert property (
    $rose(fef_loaded) |-> far_end_fault_enable_out == $past(fiber_mode_in))
    else $error("far-end fault default wrong");
  fef_write_a: assert property (
    (wr_special && fef_loaded) |=> far_end_fault_enable_out == $past(pwdata_in[FEF_EN_BIT]))
    else $error("far-end fault enable not written");
  reserved_zero_a: assert property (
    (ce_in && setup_phase && hit_special) |=>
      prdata_out[31:16] == '0 && prdata_out[12] == 1'b0 &&
      prdata_out[10:6] == '0 && prdata_out[3:0] == '0)
    else $error("reserved bits read nonzero");
  pol_track_a: assert property (
    ce_in ##1 (ce_in && setup_phase && hit_special) |=>
      prdata_out[POL_BIT] == $past(polarity_reversed_in, 2))
    else $error("polarity status wrong");
  read_keep_a: assert property (
    (pready_out && !pwrite_in && hit_symerr && !sym_err_in) |=> $stable(symbol_error_count))
    else $error("counter read changed count");
  ro_write_a: assert property (
    (pready_out && pwrite_in && hit_symerr && !sym_err_in) |=> $stable(symbol_error_count))
    else $error("counter write took effect");
  // clock enable low must freeze everything the bus and the phy can see
  ce_freeze_a: assert property (
    !ce_in |=> $stable(crossover_mode_out) && $stable(prdata_out) &&
      $stable(symbol_error_count) && $stable(special_view))
    else $error("state moved with clock enable low");
  src_keep_a: assert property (
    (ce_in && phy_reset_only_field && !wr_special) |=> $stable(crossover_source_select))
    else $error("soft phy reset touched source select");
  fef_keep_a: assert property (
    (ce_in && phy_reset_only_field && !wr_special && fef_loaded) |=>
      $stable(far_end_fault_enable_out))
    else $error("soft phy reset touched far-end fault");
  unmap_keep_a: assert property (
    (pslverr_out && fef_loaded && !phy_reset_only_field) |=> $stable(special_view[15:5]))
    else $error("unmapped write changed a field");

  write_c:  cover property (wr_special && pwdata_in[SRC_SEL_BIT]);
  reset_c:  cover property (ce_in && phy_reset_only_field);
  unmap_c:  cover property (pslverr_out);
  cnt_rd_c: cover property (pready_out && !pwrite_in && hit_symerr);
endmodule
`default_nettype wire

// ===== verif/phy_symerr_crossover_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
// register bank bench: apb tasks, expected count kept in a shadow register, control words built by ctrl
module phy_symerr_crossover_ctrl_test;
  import phy_regs_pkg::*;
  logic              clk_in;        // 200 mhz bench clock
  logic              arst_n_in;     // async reset, active low
  logic              ce_in;         // clock enable
  logic              psel;          // apb select
  logic              penable;       // apb enable
  logic              pwrite;        // apb direction
  logic [ADDR_W-1:0] paddr;         // apb byte address
  logic [DATA_W-1:0] pwdata;        // apb write data
  logic [DATA_W-1:0] prdata;        // apb read data
  logic              pready;        // apb ready
  logic              pslverr;       // apb error
  logic              sym_err;       // invalid symbol pulse
  logic              pkt_active;    // packet in progress
  logic              mode_10bt;     // 10 mb/s twisted pair
  logic              fiber_mode;    // fiber port
  logic              pol_rev;       // receive polarity reversed
  logic              phy_rst_req;   // phy reset pulse
  logic              soft_bit;      // soft reset bit level
  logic              auto_strap;    // auto crossover strap
  logic              manual_strap;  // manual crossover strap
  xover_mode_e       xmode;         // decoded crossover mode
  logic              hb_dis;        // heartbeat test disable
  logic              fef_en;        // far-end fault enable
  int                bad_count;     // mismatches
  int                num_checks;    // comparisons
  logic [15:0]       exp_cnt;       // shadow of the symbol error count
  logic [DATA_W-1:0] rd;            // scratch read data
  logic              err;           // scratch error flag

  phy_symerr_crossover_ctrl #(.CNT_W(16)) u_phy_symerr_crossover_ctrl (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .sym_err_in(sym_err), .pkt_active_in(pkt_active), .mode_10bt_in(mode_10bt),
    .fiber_mode_in(fiber_mode), .polarity_reversed_in(pol_rev),
    .phy_reset_req_in(phy_rst_req), .phy_soft_reset_bit_in(soft_bit),
    .auto_strap_in(auto_strap), .manual_strap_in(manual_strap),
    .crossover_mode_out(xmode), .heartbeat_test_disable_out(hb_dis),
    .far_end_fault_enable_out(fef_en)
  );

  // free-running clock, 5 ns period
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // one comparison, four-state safe
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic serr);
    int n;
    n = 0;
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    // bounded wait; a stuck slave is a mismatch, not a hang
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // a stuck slave ends the run through the verdict
    if (n >= 50) begin
      chk("pready", 32'h1, {31'h0, pready});
      results();
    end
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd, rd, err);
  endtask

  // read and compare data and error response
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp,
                        input logic experr);
    apb(1'b0, addr, 32'h0, rd, err);
    chk(name, exp, rd);
    chk({name, "_err"}, {31'h0, experr}, {31'h0, err});
  endtask

  // expected control word; reserved bits always zero
  function automatic logic [31:0] ctrl(input int s, input int a, input int t,
                                       input int h, input int f, input int p);
    return {16'h0, s[0], a[0], t[0], 1'b0, h[0], 5'h0, f[0], p[0], 4'h0};
  endfunction

  // let registered outputs land after an input change
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_in);
      sym_err <= 1'b1;
      @(posedge clk_in);
      sym_err <= 1'b0;
    end
  endtask

  // a packet carrying n invalid symbols
  task automatic packet(input int n);
    @(posedge clk_in);
    pkt_active <= 1'b1;
    pulses(n);
    @(posedge clk_in);
    pkt_active <= 1'b0;
    @(posedge clk_in);
  endtask

  // async reset held for three cycles with a chosen fiber setting
  task automatic do_reset(input logic fib);
    @(posedge clk_in);
    fiber_mode <= fib;
    arst_n_in  <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in  <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog sized above the wrap test, the longest part
  initial begin
    repeat (90000) @(posedge clk_in);
    bad_count++;
    $display("[FAIL] watchdog expected done seen running");
    results();
  end

  initial begin
    bad_count = 0; num_checks = 0; exp_cnt = 16'h0;
    arst_n_in = 1'b0; ce_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; sym_err = 1'b0; pkt_active = 1'b0; mode_10bt = 1'b0;
    fiber_mode = 1'b0; pol_rev = 1'b0; phy_rst_req = 1'b0; soft_bit = 1'b0;
    auto_strap = 1'b0; manual_strap = 1'b0;
    do_reset(1'b0);
    rd_chk("cnt_rst", SYMERR_ADDR, 32'h0, 1'b0);
    rd_chk("ctrl_rst", SPECIAL_ADDR, ctrl(0, 0, 0, 0, 0, 0), 1'b0);
    $display("test reset done");

    pulses(2);
    exp_cnt = exp_cnt + 16'h2;
    rd_chk("cnt_idle", SYMERR_ADDR, {16'h0, exp_cnt}, 1'b0);
    packet(3);
    exp_cnt = exp_cnt + 16'h1;
    rd_chk("cnt_pkt", SYMERR_ADDR, {16'h0, exp_cnt}, 1'b0);
    mode_10bt <= 1'b1;
    pulses(2);
    packet(2);
    mode_10bt <= 1'b0;
    rd_chk("cnt_10bt", SYMERR_ADDR, {16'h0, exp_cnt}, 1'b0);
    wr_reg(SYMERR_ADDR, 32'h0000_ffff);
    rd_chk("cnt_ro", SYMERR_ADDR, {16'h0, exp_cnt}, 1'b0);
    // clock enable low: errors arriving now must not count
    ce_in <= 1'b0;
    pulses(2);
    ce_in <= 1'b1;
    rd_chk("cnt_frozen", SYMERR_ADDR, {16'h0, exp_cnt}, 1'b0);
    $display("test counter done");

    // all writable fields but the state bit set, reserved and status bits written as ones
    wr_reg(SPECIAL_ADDR, 32'hffff_dfff);
    rd_chk("ctrl_rw", SPECIAL_ADDR, ctrl(1, 1, 0, 1, 1, 0), 1'b0);
    settle();
    chk("hb_out", 32'h1, {31'h0, hb_dis});
    chk("fef_out", 32'h1, {31'h0, fef_en});
    chk("mode_auto", {30'h0, XOVER_AUTO}, {30'h0, xmode});
    wr_reg(SPECIAL_ADDR, 32'h0);
    settle();
    chk("hb_clr", 32'h0, {31'h0, hb_dis});
    chk("fef_clr", 32'h0, {31'h0, fef_en});
    @(posedge clk_in);
    pol_rev <= 1'b1;
    settle();
    rd_chk("pol_rev", SPECIAL_ADDR, ctrl(0, 0, 0, 0, 0, 1), 1'b0);
    pol_rev <= 1'b0;
    settle();
    rd_chk("pol_norm", SPECIAL_ADDR, ctrl(0, 0, 0, 0, 0, 0), 1'b0);
    $display("test fields done");

    // every strap combination with the select at zero
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      auto_strap   <= i[1];
      manual_strap <= i[0];
      settle();
      chk("strap_mode", i[1] ? 32'h2 : {31'h0, i[0]}, {30'h0, xmode});
    end
    // register control with straps pointing at auto, reserved combination left out
    for (int i = 0; i < 3; i++) begin
      wr_reg(SPECIAL_ADDR, {16'h0, 1'b1, i[1], i[0], 13'h0});
      settle();
      chk("reg_mode", i[1] ? 32'h2 : {31'h0, i[0]}, {30'h0, xmode});
    end
    @(posedge clk_in);
    auto_strap <= 1'b0;
    $display("test crossover done");

    wr_reg(SPECIAL_ADDR, 32'h0000_c820);
    @(posedge clk_in);
    phy_rst_req <= 1'b1;
    @(posedge clk_in);
    phy_rst_req <= 1'b0;
    rd_chk("srst_gated", SPECIAL_ADDR, ctrl(1, 1, 0, 1, 1, 0), 1'b0);
    soft_bit <= 1'b1;
    @(posedge clk_in);
    phy_rst_req <= 1'b1;
    @(posedge clk_in);
    phy_rst_req <= 1'b0;
    soft_bit    <= 1'b0;
    rd_chk("srst_clear", SPECIAL_ADDR, ctrl(1, 0, 0, 0, 1, 0), 1'b0);
    settle();
    chk("srst_hb", 32'h0, {31'h0, hb_dis});
    chk("srst_mode", {30'h0, XOVER_STRAIGHT}, {30'h0, xmode});
    $display("test soft reset done");

    rd_chk("unmapped", 8'h70, 32'h0, 1'b1);
    wr_reg(8'h70, 32'h0000_ffff);
    rd_chk("unmapped_wr", SPECIAL_ADDR, ctrl(1, 0, 0, 0, 1, 0), 1'b0);
    $display("test unmapped done");

    // idle errors every cycle up to exactly the wrap point
    @(posedge clk_in);
    sym_err <= 1'b1;
    repeat (32'h10000 - exp_cnt) @(posedge clk_in);
    sym_err <= 1'b0;
    exp_cnt = 16'h0;
    @(posedge clk_in);
    rd_chk("cnt_wrap", SYMERR_ADDR, {16'h0, exp_cnt}, 1'b0);
    pulses(1);
    rd_chk("cnt_after", SYMERR_ADDR, 32'h1, 1'b0);
    $display("test wrap done");

    // fiber port from here on, so far-end fault defaults to enabled
    do_reset(1'b1);
    rd_chk("fiber_rst", SPECIAL_ADDR, ctrl(0, 0, 0, 0, 1, 0), 1'b0);
    rd_chk("cnt_rst2", SYMERR_ADDR, 32'h0, 1'b0);
    chk("fef_fiber", 32'h1, {31'h0, fef_en});
    $display("test fiber reset done");
    results();
  end
endmodule
`default_nettype wire
